/* File: rtl/ctml_pkg.sv */
// Constants, register map and state encodings of the CAN transceiver mode logic.
package ctml_pkg;

	////////////////////////////////////////////////////////////////////////////////
	localparam int unsigned CLK_MHZ = 50;
	localparam int unsigned CNT_W = 20;

	// Times in their own units; least times round up, longest times round down.
	localparam int unsigned WAKE_FILT_NS = 1000;
	localparam int unsigned WAKE_WINDOW_US = 1000;
	localparam int unsigned DOM_TIMEOUT_US = 1000;
	localparam int unsigned STBY_TO_NORMAL_US = 10;

	localparam int unsigned WAKE_FILT_RAW = (WAKE_FILT_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned WAKE_FILT_CYC = (WAKE_FILT_RAW < 1) ? 1 : WAKE_FILT_RAW;
	localparam int unsigned WAKE_WINDOW_RAW = WAKE_WINDOW_US * CLK_MHZ;
	localparam int unsigned WAKE_WINDOW_CYC = (WAKE_WINDOW_RAW < 1) ? 1 : WAKE_WINDOW_RAW;
	localparam int unsigned DOM_TIMEOUT_RAW = DOM_TIMEOUT_US * CLK_MHZ;
	localparam int unsigned DOM_TIMEOUT_CYC = (DOM_TIMEOUT_RAW < 1) ? 1 : DOM_TIMEOUT_RAW;
	localparam int unsigned STBY_TO_NORMAL_RAW = STBY_TO_NORMAL_US * CLK_MHZ;
	localparam int unsigned STBY_TO_NORMAL_CYC = (STBY_TO_NORMAL_RAW < 1) ? 1 : STBY_TO_NORMAL_RAW;

	////////////////////////////////////////////////////////////////////////////////
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] CTRL_OFFS = 8'h00;
	localparam logic [7:0] STATUS_OFFS = 8'h04;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int unsigned CTRL_FORCE_STBY_BIT = 0;

	localparam int unsigned STAT_MODE_LSB = 0;
	localparam int unsigned STAT_WAKE_BIT = 4;
	localparam int unsigned STAT_DOM_TO_BIT = 5;
	localparam int unsigned STAT_THERM_BIT = 6;
	localparam int unsigned STAT_LOCK_BIT = 7;
	localparam int unsigned STAT_DISENGAGE_BIT = 8;
	localparam int unsigned STAT_UV_STBY_BIT = 9;
	localparam int unsigned STAT_TX_EN_BIT = 10;

	////////////////////////////////////////////////////////////////////////////////
	typedef enum logic [3:0] {
		MODE_OFF = 4'h1,
		MODE_STANDBY = 4'h2,
		MODE_RECOVER = 4'h4,
		MODE_NORMAL = 4'h8
	} ctml_mode_type;

	typedef enum logic [3:0] {
		WAKE_IDLE = 4'h1,
		WAKE_DOM1 = 4'h2,
		WAKE_REC = 4'h4,
		WAKE_DOM2 = 4'h8
	} ctml_wake_type;

endpackage : ctml_pkg

/* File: rtl/ctml_sync.sv */
// Two-flip-flop synchroniser bank for pins and analog detector flags.
`timescale 1ns/1ps
`default_nettype none

module ctml_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} ctml_sync_state_type;

	ctml_sync_state_type s_q;
	ctml_sync_state_type s_d;

	generate
		if (WIDTH < 1) begin : g_chk
			$error("Synchroniser width must be at least one.");
		end
	endgenerate

	always_comb begin
		s_d.meta = d_in;
		s_d.sync = s_q.meta;
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q_out = s_q.sync;

endmodule : ctml_sync

`default_nettype wire

/* File: rtl/ctml_top.sv */
// Mode, wake-up, dominant-timeout, thermal and undervoltage logic of a CAN transceiver with APB registers.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Standby select low normal, high standby.
// - Normal mode: forward transmit, receive mirrors bus.
// - Transmit low drives dominant, high recessive.
// - Standby disables transmitter and receiver; low-power watches.
// - Standby biases bus lines toward ground.
// - Wake needs dominant, recessive, dominant, each filtered.
// - Whole pattern within window, else restart.
// - After wake, receive output follows bus.
// - Overtemperature switches transmitter off only.
// - Thermal off held until cool and transmit high.
// - Falling transmit edge starts dominant timer.
// - Transmit low too long disables transmitter.
// - Rising transmit edge clears timer and timeout.
// - Main supply undervoltage forces standby.
// - I/O supply undervoltage also forces standby.
// - Switch-off undervoltage disengages until supply recovers.
// - After recovery, transmit must go high first.
// - Undervoltage recovery equals standby-to-normal time.
// - Unconnected transmit or standby inputs read high.
// - Wake detection runs from I/O supply.
module ctml_top #(
	parameter bit HAS_IO_SUPPLY = 1'b1,
	parameter int unsigned WAKE_FILT_CYC = ctml_pkg::WAKE_FILT_CYC,
	parameter int unsigned WAKE_WINDOW_CYC = ctml_pkg::WAKE_WINDOW_CYC,
	parameter int unsigned DOM_TIMEOUT_CYC = ctml_pkg::DOM_TIMEOUT_CYC,
	parameter int unsigned STBY_TO_NORMAL_CYC = ctml_pkg::STBY_TO_NORMAL_CYC
) (
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [ctml_pkg::ADDR_W-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic TX_DATA_IN,
	input wire logic TX_DATA_FLOAT_IN,
	input wire logic STBY_SEL_IN,
	input wire logic STBY_SEL_FLOAT_IN,
	input wire logic BUS_DOMINANT_IN,
	input wire logic OVERTEMP_IN,
	input wire logic MAIN_UV_STBY_IN,
	input wire logic MAIN_UV_OFF_IN,
	input wire logic IO_UV_STBY_IN,
	input wire logic IO_UV_OFF_IN,
	output logic RX_DATA_OUT,
	output logic TX_ENABLE_OUT,
	output logic BUS_DRIVE_DOM_OUT,
	output logic NORMAL_RX_EN_OUT,
	output logic LP_RX_EN_OUT,
	output logic BUS_BIAS_GND_OUT,
	output logic BUS_DISENGAGE_OUT,
	output logic WAKE_DETECTED_OUT,
	output logic DOM_TIMEOUT_OUT,
	output logic THERMAL_OFF_OUT
);

	localparam int unsigned CW = ctml_pkg::CNT_W;
	localparam int unsigned NSYNC = 10;

	generate
		if (WAKE_FILT_CYC < 1 || WAKE_WINDOW_CYC < 1 || DOM_TIMEOUT_CYC < 1 || STBY_TO_NORMAL_CYC < 1) begin : g_chk_min
			$error("Timer counts must be at least one cycle.");
		end
		if (WAKE_FILT_CYC >= (1 << CW) || WAKE_WINDOW_CYC >= (1 << CW) || DOM_TIMEOUT_CYC >= (1 << CW)
			|| STBY_TO_NORMAL_CYC >= (1 << CW)) begin : g_chk_max
			$error("Timer counts do not fit the counter width.");
		end
		if (WAKE_FILT_CYC * 3 > WAKE_WINDOW_CYC) begin : g_chk_win
			$error("Wake window cannot hold three filtered phases.");
		end
	endgenerate

	typedef struct packed {
		ctml_pkg::ctml_mode_type mode;
		ctml_pkg::ctml_wake_type wake_st;
		logic [CW-1:0] mode_cnt;
		logic [CW-1:0] phase_cnt;
		logic [CW-1:0] win_cnt;
		logic [CW-1:0] dom_cnt;
		logic wake;
		logic dom_to;
		logic therm;
		logic lock;
		logic tx_prev;
		logic [31:0] ctrl;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic rx_data;
		logic tx_en;
		logic drive_dom;
		logic normal_rx_en;
		logic lp_rx_en;
		logic bias_gnd;
		logic disengage;
	} ctml_state_type;

	ctml_state_type s_q;
	ctml_state_type s_d;

	logic [NSYNC-1:0] pins_raw;
	logic [NSYNC-1:0] pins_s;

	// Saturating increment keeps a held timer from wrapping back into range.
	function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
		sat_inc = (v == {CW{1'b1}}) ? v : v + {{(CW-1){1'b0}}, 1'b1};
	endfunction : sat_inc

	////////////////////////////////////////////////////////////////////////////////
	// Transmit and standby select pass inverted, so the cleared synchroniser reads them released and no false edge follows reset.
	assign pins_raw = {~TX_DATA_IN, TX_DATA_FLOAT_IN, ~STBY_SEL_IN, STBY_SEL_FLOAT_IN, BUS_DOMINANT_IN,
		OVERTEMP_IN, MAIN_UV_STBY_IN, MAIN_UV_OFF_IN, IO_UV_STBY_IN, IO_UV_OFF_IN};

	ctml_sync #(
		.WIDTH(NSYNC)
	) u_sync (
		.clk_in(CLK_IN),
		.arst_n_in(ARST_N_IN),
		.d_in(pins_raw),
		.q_out(pins_s)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic txd;
		logic stb;
		logic bus_dom;
		logic otemp;
		logic uv_stby;
		logic main_off;
		logic io_off;
		logic powered;
		logic want_normal;
		logic tx_rise;
		logic tx_fall;
		logic apb_acc;
		logic [31:0] status;
		txd = !pins_s[9] | pins_s[8];
		stb = !pins_s[7] | pins_s[6];
		bus_dom = pins_s[5];
		otemp = pins_s[4];
		main_off = pins_s[2];
		io_off = HAS_IO_SUPPLY & pins_s[0];
		uv_stby = pins_s[3] | main_off | (HAS_IO_SUPPLY & (pins_s[1] | io_off));
		// With a separate I/O supply the wake path survives loss of the main supply.
		powered = HAS_IO_SUPPLY ? !io_off : !main_off;
		want_normal = !stb && !uv_stby && !s_q.ctrl[ctml_pkg::CTRL_FORCE_STBY_BIT];
		tx_rise = txd && !s_q.tx_prev;
		tx_fall = !txd && s_q.tx_prev;
		s_d = s_q;
		s_d.tx_prev = txd;

		// Operating mode.
		unique case (s_q.mode)
			ctml_pkg::MODE_OFF: begin
				if (powered) begin
					s_d.mode = ctml_pkg::MODE_STANDBY;
				end
			end
			ctml_pkg::MODE_STANDBY: begin
				if (want_normal) begin
					s_d.mode = ctml_pkg::MODE_RECOVER;
					s_d.mode_cnt = '0;
				end
			end
			ctml_pkg::MODE_RECOVER: begin
				s_d.mode_cnt = sat_inc(s_q.mode_cnt);
				if (!want_normal) begin
					s_d.mode = ctml_pkg::MODE_STANDBY;
				end else if (s_d.mode_cnt >= CW'(STBY_TO_NORMAL_CYC)) begin
					s_d.mode = ctml_pkg::MODE_NORMAL;
				end
			end
			ctml_pkg::MODE_NORMAL: begin
				if (!want_normal) begin
					s_d.mode = ctml_pkg::MODE_STANDBY;
				end
			end
			default: begin
				s_d.mode = ctml_pkg::MODE_OFF;
			end
		endcase
		if (!powered) begin
			s_d.mode = ctml_pkg::MODE_OFF;
		end

		// Any undervoltage arms the lock; only a high transmit input with good supplies releases it.
		if (uv_stby || !powered) begin
			s_d.lock = 1'b1;
		end else if (txd) begin
			s_d.lock = 1'b0;
		end

		// Dominant timeout runs on the transmit input in every mode.
		if (tx_rise) begin
			s_d.dom_cnt = '0;
			s_d.dom_to = 1'b0;
		end else if (tx_fall) begin
			s_d.dom_cnt = {{(CW-1){1'b0}}, 1'b1};
		end else if (!txd && s_q.dom_cnt != '0) begin
			s_d.dom_cnt = sat_inc(s_q.dom_cnt);
			if (s_q.dom_cnt >= CW'(DOM_TIMEOUT_CYC)) begin
				s_d.dom_to = 1'b1;
			end
		end

		// Thermal latch; a fresh overtemperature wins over the release.
		if (otemp) begin
			s_d.therm = 1'b1;
		end else if (txd) begin
			s_d.therm = 1'b0;
		end

		// Wake pattern detector, active only outside normal mode while powered.
		if (s_d.mode == ctml_pkg::MODE_NORMAL || s_d.mode == ctml_pkg::MODE_OFF) begin
			s_d.wake_st = ctml_pkg::WAKE_IDLE;
			s_d.wake = 1'b0;
			s_d.phase_cnt = '0;
			s_d.win_cnt = '0;
		end else if (!s_q.wake) begin
			s_d.win_cnt = sat_inc(s_q.win_cnt);
			s_d.phase_cnt = sat_inc(s_q.phase_cnt);
			unique case (s_q.wake_st)
				ctml_pkg::WAKE_IDLE: begin
					s_d.win_cnt = {{(CW-1){1'b0}}, 1'b1};
					s_d.phase_cnt = {{(CW-1){1'b0}}, 1'b1};
					if (bus_dom) begin
						s_d.wake_st = ctml_pkg::WAKE_DOM1;
					end
				end
				ctml_pkg::WAKE_DOM1: begin
					if (!bus_dom) begin
						s_d.phase_cnt = {{(CW-1){1'b0}}, 1'b1};
						s_d.wake_st = (s_q.phase_cnt >= CW'(WAKE_FILT_CYC)) ? ctml_pkg::WAKE_REC
							: ctml_pkg::WAKE_IDLE;
					end
				end
				ctml_pkg::WAKE_REC: begin
					if (bus_dom) begin
						s_d.phase_cnt = {{(CW-1){1'b0}}, 1'b1};
						s_d.wake_st = (s_q.phase_cnt >= CW'(WAKE_FILT_CYC)) ? ctml_pkg::WAKE_DOM2
							: ctml_pkg::WAKE_IDLE;
					end
				end
				ctml_pkg::WAKE_DOM2: begin
					if (!bus_dom) begin
						s_d.wake_st = ctml_pkg::WAKE_IDLE;
					end else if (s_d.phase_cnt >= CW'(WAKE_FILT_CYC)) begin
						s_d.wake = 1'b1;
						s_d.wake_st = ctml_pkg::WAKE_IDLE;
					end
				end
				default: begin
					s_d.wake_st = ctml_pkg::WAKE_IDLE;
				end
			endcase
			if (!s_d.wake && s_q.wake_st != ctml_pkg::WAKE_IDLE && s_q.win_cnt >= CW'(WAKE_WINDOW_CYC)) begin
				s_d.wake_st = ctml_pkg::WAKE_IDLE;
			end
		end

		// Pin-level outputs are registered from the next state so they lag nothing.
		s_d.disengage = main_off | io_off;
		s_d.tx_en = (s_d.mode == ctml_pkg::MODE_NORMAL) && !s_d.therm && !s_d.dom_to && !s_d.lock
			&& !s_d.disengage;
		s_d.drive_dom = s_d.tx_en && !txd;
		s_d.normal_rx_en = (s_d.mode == ctml_pkg::MODE_NORMAL);
		s_d.lp_rx_en = (s_d.mode == ctml_pkg::MODE_STANDBY) || (s_d.mode == ctml_pkg::MODE_RECOVER);
		s_d.bias_gnd = s_d.lp_rx_en;
		if (s_d.mode == ctml_pkg::MODE_NORMAL) begin
			s_d.rx_data = !bus_dom;
		end else if (s_d.lp_rx_en && s_d.wake) begin
			s_d.rx_data = !bus_dom;
		end else begin
			s_d.rx_data = 1'b1;
		end

		// APB slave with one wait state: the access phase always lasts two cycles.
		status = '0;
		status[ctml_pkg::STAT_MODE_LSB +: 4] = s_q.mode;
		status[ctml_pkg::STAT_WAKE_BIT] = s_q.wake;
		status[ctml_pkg::STAT_DOM_TO_BIT] = s_q.dom_to;
		status[ctml_pkg::STAT_THERM_BIT] = s_q.therm;
		status[ctml_pkg::STAT_LOCK_BIT] = s_q.lock;
		status[ctml_pkg::STAT_DISENGAGE_BIT] = s_q.disengage;
		status[ctml_pkg::STAT_UV_STBY_BIT] = uv_stby;
		status[ctml_pkg::STAT_TX_EN_BIT] = s_q.tx_en;
		apb_acc = PSEL_IN && PENABLE_IN && !s_q.pready;
		s_d.pready = apb_acc;
		s_d.pslverr = apb_acc && (PADDR_IN != ctml_pkg::CTRL_OFFS) && (PADDR_IN != ctml_pkg::STATUS_OFFS);
		s_d.prdata = '0;
		if (apb_acc && !PWRITE_IN) begin
			if (PADDR_IN == ctml_pkg::CTRL_OFFS) begin
				s_d.prdata = s_q.ctrl;
			end else if (PADDR_IN == ctml_pkg::STATUS_OFFS) begin
				s_d.prdata = status;
			end
		end
		if (PSEL_IN && PENABLE_IN && s_q.pready && PWRITE_IN && PADDR_IN == ctml_pkg::CTRL_OFFS) begin
			s_d.ctrl = 32'h0000_0000;
			s_d.ctrl[ctml_pkg::CTRL_FORCE_STBY_BIT] = PWDATA_IN[ctml_pkg::CTRL_FORCE_STBY_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			s_q <= '0;
			s_q.mode <= ctml_pkg::MODE_OFF;
			s_q.wake_st <= ctml_pkg::WAKE_IDLE;
			s_q.ctrl <= ctml_pkg::CTRL_RESET;
			s_q.lock <= 1'b1;
			s_q.tx_prev <= 1'b1;
			s_q.rx_data <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign PRDATA_OUT = s_q.prdata;
	assign PREADY_OUT = s_q.pready;
	assign PSLVERR_OUT = s_q.pslverr;
	assign RX_DATA_OUT = s_q.rx_data;
	assign TX_ENABLE_OUT = s_q.tx_en;
	assign BUS_DRIVE_DOM_OUT = s_q.drive_dom;
	assign NORMAL_RX_EN_OUT = s_q.normal_rx_en;
	assign LP_RX_EN_OUT = s_q.lp_rx_en;
	assign BUS_BIAS_GND_OUT = s_q.bias_gnd;
	assign BUS_DISENGAGE_OUT = s_q.disengage;
	assign WAKE_DETECTED_OUT = s_q.wake;
	assign DOM_TIMEOUT_OUT = s_q.dom_to;
	assign THERMAL_OFF_OUT = s_q.therm;

endmodule : ctml_top

`default_nettype wire

/* File: tb/ctml_ctrl_model.sv */
// Protocol controller model that drives the transmit and standby pins.
`timescale 1ns/1ps
`default_nettype none
module ctml_ctrl_model (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic tx_req_in,
	input wire logic stby_req_in,
	output logic tx_data_out,
	output logic stby_sel_out
);
	// Pins come up released high, as a controller leaves them before it is set up.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tx_data_out <= 1'b1;
			stby_sel_out <= 1'b1;
		end else begin
			// Requests are bit levels well above 17 kbps, so a legal dominant run stays short.
			tx_data_out <= tx_req_in;
			stby_sel_out <= stby_req_in;
		end
	end
endmodule : ctml_ctrl_model
`default_nettype wire

/* File: tb/ctml_chk_sva.sv */
// Concurrent checks on the pins of the transceiver mode logic.
`timescale 1ns/1ps
`default_nettype none
module ctml_chk (
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PREADY_OUT,
	input wire logic TX_DATA_IN,
	input wire logic TX_DATA_FLOAT_IN,
	input wire logic STBY_SEL_IN,
	input wire logic BUS_DOMINANT_IN,
	input wire logic MAIN_UV_OFF_IN,
	input wire logic RX_DATA_OUT,
	input wire logic TX_ENABLE_OUT,
	input wire logic BUS_DRIVE_DOM_OUT,
	input wire logic NORMAL_RX_EN_OUT,
	input wire logic LP_RX_EN_OUT,
	input wire logic BUS_BIAS_GND_OUT,
	input wire logic BUS_DISENGAGE_OUT,
	input wire logic WAKE_DETECTED_OUT,
	input wire logic DOM_TIMEOUT_OUT,
	input wire logic THERMAL_OFF_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!ARST_N_IN);
	////////////////////////////////////////
	// Five samples cover the two sync flops and the state flop, which also registers the outputs.
	sequence s_tx_high5;
		(TX_DATA_IN || TX_DATA_FLOAT_IN) [*5];
	endsequence
	sequence s_sel_high5;
		STBY_SEL_IN [*5];
	endsequence
	sequence s_off5;
		MAIN_UV_OFF_IN [*5];
	endsequence
	////////////////////////////////////////
	AST_SEL: assert property (s_sel_high5 |-> !NORMAL_RX_EN_OUT)
		else $error("normal receiver on with standby selected");
	AST_RX_NORMAL: assert property (NORMAL_RX_EN_OUT && $past(NORMAL_RX_EN_OUT) |-> RX_DATA_OUT == !$past(BUS_DOMINANT_IN, 3))
		else $error("receive output not mirroring bus");
	AST_DRIVE: assert property (BUS_DRIVE_DOM_OUT |-> TX_ENABLE_OUT && !DOM_TIMEOUT_OUT && !THERMAL_OFF_OUT)
		else $error("dominant drive while transmitter barred");
	AST_STBY_OFF: assert property (LP_RX_EN_OUT |-> !TX_ENABLE_OUT && !NORMAL_RX_EN_OUT)
		else $error("normal paths on in standby");
	AST_BIAS: assert property (BUS_BIAS_GND_OUT == LP_RX_EN_OUT)
		else $error("ground bias differs from standby");
	AST_RX_STBY: assert property (LP_RX_EN_OUT && !WAKE_DETECTED_OUT |-> RX_DATA_OUT)
		else $error("receive output low before wake");
	AST_WAKE_RX: assert property (WAKE_DETECTED_OUT && $past(WAKE_DETECTED_OUT) |-> RX_DATA_OUT == !$past(BUS_DOMINANT_IN, 3))
		else $error("receive output not following bus after wake");
	AST_THERM: assert property (THERMAL_OFF_OUT |-> !TX_ENABLE_OUT)
		else $error("transmitter on during thermal off");
	AST_TO_CLEAR: assert property (s_tx_high5 |-> !DOM_TIMEOUT_OUT)
		else $error("timeout kept with transmit high");
	AST_DISENG: assert property (s_off5 |-> BUS_DISENGAGE_OUT)
		else $error("no disengage on switch-off level");
	AST_APB: assert property (PSEL_IN && $rose(PENABLE_IN) |=> PREADY_OUT ##1 !PREADY_OUT)
		else $error("ready pulse misplaced");
endmodule : ctml_chk
`default_nettype wire

/* File: tb/can_transceiver_mode_logic_test.sv */
// Self-checking bench of the transceiver mode logic.
`timescale 1ns/1ps
`default_nettype none
bind ctml_top ctml_chk u_chk (.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.PREADY_OUT(PREADY_OUT), .TX_DATA_IN(TX_DATA_IN), .TX_DATA_FLOAT_IN(TX_DATA_FLOAT_IN), .STBY_SEL_IN(STBY_SEL_IN),
	.BUS_DOMINANT_IN(BUS_DOMINANT_IN), .MAIN_UV_OFF_IN(MAIN_UV_OFF_IN), .RX_DATA_OUT(RX_DATA_OUT),
	.TX_ENABLE_OUT(TX_ENABLE_OUT), .BUS_DRIVE_DOM_OUT(BUS_DRIVE_DOM_OUT), .NORMAL_RX_EN_OUT(NORMAL_RX_EN_OUT),
	.LP_RX_EN_OUT(LP_RX_EN_OUT), .BUS_BIAS_GND_OUT(BUS_BIAS_GND_OUT), .BUS_DISENGAGE_OUT(BUS_DISENGAGE_OUT),
	.WAKE_DETECTED_OUT(WAKE_DETECTED_OUT), .DOM_TIMEOUT_OUT(DOM_TIMEOUT_OUT), .THERMAL_OFF_OUT(THERMAL_OFF_OUT));
module can_transceiver_mode_logic_test;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd, prdata;
	logic tx_req = 1'b1, stby_req = 1'b1, tx_flt = 1'b0, sel_flt = 1'b0, bus_dom = 1'b0, otemp = 1'b0;
	logic muvs = 1'b0, muvo = 1'b0, iuvs = 1'b0, iuvo = 1'b0;
	logic pready, pslverr, rx, txen, drv, nrx, lprx, bias, diseng, wake, dto, thoff, tx_pin, sel_pin;
	int error_cnt = 0, check_count = 0;
	ctml_ctrl_model u_ctrl (.clk_in(clk), .arst_n_in(rst_n), .tx_req_in(tx_req), .stby_req_in(stby_req),
		.tx_data_out(tx_pin), .stby_sel_out(sel_pin));
	ctml_top #(.WAKE_FILT_CYC(4), .WAKE_WINDOW_CYC(40), .DOM_TIMEOUT_CYC(20), .STBY_TO_NORMAL_CYC(5)) dut (
		.CLK_IN(clk), .ARST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TX_DATA_IN(tx_pin),
		.TX_DATA_FLOAT_IN(tx_flt), .STBY_SEL_IN(sel_pin), .STBY_SEL_FLOAT_IN(sel_flt), .BUS_DOMINANT_IN(bus_dom),
		.OVERTEMP_IN(otemp), .MAIN_UV_STBY_IN(muvs), .MAIN_UV_OFF_IN(muvo), .IO_UV_STBY_IN(iuvs), .IO_UV_OFF_IN(iuvo),
		.RX_DATA_OUT(rx), .TX_ENABLE_OUT(txen), .BUS_DRIVE_DOM_OUT(drv), .NORMAL_RX_EN_OUT(nrx), .LP_RX_EN_OUT(lprx),
		.BUS_BIAS_GND_OUT(bias), .BUS_DISENGAGE_OUT(diseng), .WAKE_DETECTED_OUT(wake), .DOM_TIMEOUT_OUT(dto),
		.THERMAL_OFF_OUT(thoff));
	initial begin
		forever #10 clk = ~clk;
	end
	////////////////////////////////////////
	task results();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// Outputs are read at the falling edge, where the rising-edge updates have landed.
	task look(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : look
	task ph(input logic v, input int n);
		@(posedge clk);
		bus_dom <= v;
		repeat (n) @(posedge clk);
	endtask : ph
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 8);
		if (pready !== 1'b1) begin
			error_cnt++;
			results();
		end
		// Answer is taken at the edge that samples ready high; only then is the request dropped.
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	////////////////////////////////////////
	task t_reset();
		look(20);
		chk("rx_reset", rx, 1);
		chk("drive_reset", drv, 0);
		@(posedge clk);
		rst_n <= 1'b1;
	endtask : t_reset
	task t_regs();
		look(6);
		apb(1'b0, ctml_pkg::STATUS_OFFS, 32'h0);
		chk("mode_standby", rd[3:0], 4'h2);
		apb(1'b0, ctml_pkg::CTRL_OFFS, 32'h0);
		chk("ctrl_reset", rd, ctml_pkg::CTRL_RESET);
		apb(1'b1, ctml_pkg::CTRL_OFFS, 32'h1);
		apb(1'b0, ctml_pkg::CTRL_OFFS, 32'h0);
		chk("ctrl_rw", rd, 32'h1);
		apb(1'b1, ctml_pkg::CTRL_OFFS, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped_err", err, 1);
		chk("unmapped_data", rd, 0);
	endtask : t_regs
	task t_normal();
		@(posedge clk);
		sel_flt <= 1'b1;
		stby_req <= 1'b0;
		look(15);
		chk("float_stby", nrx, 0);
		@(posedge clk);
		sel_flt <= 1'b0;
		look(15);
		chk("normal_rx", nrx, 1);
		chk("lp_rx_off", lprx, 0);
		apb(1'b0, ctml_pkg::STATUS_OFFS, 32'h0);
		chk("mode_normal", rd[3:0], 4'h8);
		apb(1'b1, ctml_pkg::CTRL_OFFS, 32'h1);
		look(3);
		chk("force_stby", nrx, 0);
		apb(1'b1, ctml_pkg::CTRL_OFFS, 32'h0);
		@(posedge clk);
		tx_flt <= 1'b1;
		tx_req <= 1'b0;
		look(6);
		chk("float_tx", drv, 0);
		@(posedge clk);
		tx_flt <= 1'b0;
		look(6);
		chk("drive_dom", drv, 1);
		@(posedge clk);
		bus_dom <= 1'b1;
		look(5);
		chk("rx_dom", rx, 0);
		@(posedge clk);
		tx_req <= 1'b1;
		bus_dom <= 1'b0;
		look(6);
		chk("drive_rec", drv, 0);
		chk("rx_rec", rx, 1);
	endtask : t_normal
	task t_timeout();
		@(posedge clk);
		tx_req <= 1'b0;
		look(12);
		chk("drive_early", drv, 1);
		chk("timeout_early", dto, 0);
		look(20);
		chk("timeout", dto, 1);
		chk("drive_cut", drv, 0);
		@(posedge clk);
		tx_req <= 1'b1;
		look(6);
		chk("timeout_clear", dto, 0);
		@(posedge clk);
		tx_req <= 1'b0;
		look(6);
		chk("drive_again", drv, 1);
		@(posedge clk);
		tx_req <= 1'b1;
		look(6);
	endtask : t_timeout
	task t_thermal();
		@(posedge clk);
		otemp <= 1'b1;
		bus_dom <= 1'b1;
		look(6);
		chk("thermal_set", thoff, 1);
		chk("thermal_txen", txen, 0);
		chk("thermal_rx", rx, 0);
		@(posedge clk);
		bus_dom <= 1'b0;
		tx_req <= 1'b0;
		// Transmit reaches its pin one edge after the request, so cooling follows one edge later.
		@(posedge clk);
		otemp <= 1'b0;
		look(6);
		chk("thermal_held", thoff, 1);
		@(posedge clk);
		tx_req <= 1'b1;
		look(6);
		chk("thermal_clear", thoff, 0);
		chk("thermal_txen_back", txen, 1);
	endtask : t_thermal
	task t_uv();
		@(posedge clk);
		muvs <= 1'b1;
		look(6);
		chk("uv_txen", txen, 0);
		chk("uv_lp_rx", lprx, 1);
		@(posedge clk);
		tx_req <= 1'b0;
		@(posedge clk);
		muvs <= 1'b0;
		look(14);
		chk("uv_locked", drv, 0);
		@(posedge clk);
		tx_req <= 1'b1;
		look(4);
		@(posedge clk);
		tx_req <= 1'b0;
		look(6);
		chk("uv_unlocked", drv, 1);
		@(posedge clk);
		tx_req <= 1'b1;
		iuvs <= 1'b1;
		look(6);
		chk("io_uv_txen", txen, 0);
		@(posedge clk);
		iuvs <= 1'b0;
		muvo <= 1'b1;
		look(6);
		chk("main_off", diseng, 1);
		@(posedge clk);
		muvo <= 1'b0;
		iuvo <= 1'b1;
		look(6);
		chk("io_off", diseng, 1);
		@(posedge clk);
		iuvo <= 1'b0;
		look(3);
		chk("recover_wait", txen, 0);
		look(14);
		chk("engaged", diseng, 0);
		chk("recovered", txen, 1);
	endtask : t_uv
	task t_wake();
		@(posedge clk);
		stby_req <= 1'b1;
		look(8);
		chk("stby_lp_rx", lprx, 1);
		chk("stby_bias", bias, 1);
		ph(1'b1, 5);
		look(0);
		chk("stby_rx_high", rx, 1);
		ph(1'b0, 35);
		ph(1'b1, 6);
		ph(1'b0, 45);
		look(0);
		chk("late_pattern", wake, 0);
		ph(1'b1, 2);
		ph(1'b0, 6);
		ph(1'b1, 6);
		ph(1'b0, 45);
		look(0);
		chk("short_phase", wake, 0);
		@(posedge clk);
		muvo <= 1'b1;
		ph(1'b1, 6);
		ph(1'b0, 6);
		ph(1'b1, 10);
		look(0);
		chk("wake", wake, 1);
		chk("wake_rx", rx, 0);
		ph(1'b0, 5);
		look(0);
		chk("wake_rx_rec", rx, 1);
	endtask : t_wake
	initial begin
		t_reset();
		t_regs();
		t_normal();
		t_timeout();
		t_thermal();
		t_uv();
		t_wake();
		results();
	end
endmodule : can_transceiver_mode_logic_test
`default_nettype wire
